// ### hw/tcoc_top.sv
// tcoc_top.sv: timer compare output control, prescaler choice and fast flag clear
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "tcoc_defines.svh"
module tcoc_top (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic [15:0]        counter_value,
    input  wire logic [7:0]         compare_match,
    output logic                    counter_overflow,
    output tcoc_pkg::tcoc_clear_t   flag_clear,
    output logic      [7:0]         prescale_sel,
    output logic                    precision_mode,
    output logic      [7:0]         pin_level,
    output logic      [7:0]         pin_oe
);

    localparam int NCH = `TCOC_CHANNELS;

    // ****************************************************************
    // state
    // ****************************************************************
    tcoc_pkg::tcoc_apb_state_t st_reg;
    logic [7:0]             cap_sel_reg;
    logic [7:0]             ovr_mask_reg;
    logic [7:0]             ovr_data_reg;
    logic [7:0]             sysctl1_reg;
    logic [7:0]             tov_reg;
    logic [7:0]             act_hi_reg;
    logic [7:0]             act_lo_reg;
    logic [7:0]             sysctl2_reg;
    logic [7:0]             prec_psc_reg;
    logic [7:0]             disc_reg;
    logic                   precision_prescale_select_lock_reg;
    logic [NCH-1:0]         force_reg;
    logic [15:0]            cnt_prev_reg;
    tcoc_pkg::tcoc_clear_t  clear_next;
    logic [5:0]             idx;
    logic [2:0]             chan;
    logic                   mapped;
    logic                   commit;
    logic                   wr_commit;
    logic                   ffca;
    logic                   precision_prescale_select;
    logic                   ch7_event;
    logic [15:0]            pairs;
    logic [7:0]             rd_byte;

    // ****************************************************************
    // decode helpers
    // ****************************************************************
    function automatic logic tcoc_chan_hit(input logic [5:0] i);
        return (i >= `TCOC_IDX_CHAN_FIRST) && (i <= `TCOC_IDX_CHAN_LAST);
    endfunction : tcoc_chan_hit

    function automatic logic tcoc_is_cnt(input logic [5:0] i);
        return (i == `TCOC_IDX_CNT_HI) || (i == `TCOC_IDX_CNT_LO);
    endfunction : tcoc_is_cnt

    function automatic logic tcoc_is_acc(input logic [5:0] i);
        return (i == `TCOC_IDX_ACC_HI) || (i == `TCOC_IDX_ACC_LO);
    endfunction : tcoc_is_acc

    function automatic logic tcoc_mapped(input logic [5:0] i);
        return tcoc_chan_hit(i) || tcoc_is_cnt(i) || tcoc_is_acc(i)
            || (i inside {`TCOC_IDX_CAP_SEL, `TCOC_IDX_FORCE, `TCOC_IDX_OVR_MASK,
                          `TCOC_IDX_OVR_DATA, `TCOC_IDX_SYSCTL1, `TCOC_IDX_TOV,
                          `TCOC_IDX_ACT_HI, `TCOC_IDX_ACT_LO, `TCOC_IDX_SYSCTL2,
                          `TCOC_IDX_CHFLAG, `TCOC_IDX_FLAG2, `TCOC_IDX_ACC_FLAG,
                          `TCOC_IDX_PREC_PSC, `TCOC_IDX_PIN_DISC});
    endfunction : tcoc_mapped

    assign idx       = paddr[7:2];
    assign chan      = idx[3:1];
    assign mapped    = (paddr[1:0] == 2'h0) && tcoc_mapped(idx);
    // effects land only on the edge where the master sees pready
    assign commit    = (st_reg == tcoc_pkg::TCOC_ST_DONE) && psel && penable;
    assign wr_commit = commit && pwrite && mapped;
    assign ffca      = sysctl1_reg[`TCOC_BIT_FFCA];
    assign precision_prescale_select      = sysctl1_reg[`TCOC_BIT_PRECISION_PRESCALE_SELECT];
    assign pairs     = {act_hi_reg, act_lo_reg};

    // ****************************************************************
    // apb handshake: one wait state, read data registered
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg  <= tcoc_pkg::TCOC_ST_IDLE;
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            unique case (st_reg)
                tcoc_pkg::TCOC_ST_IDLE: begin
                    if (psel && penable) begin
                        st_reg  <= tcoc_pkg::TCOC_ST_DONE;
                        pready  <= 1'b1;
                        prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
                        pslverr <= !mapped;
                    end
                end
                tcoc_pkg::TCOC_ST_DONE: begin
                    st_reg  <= tcoc_pkg::TCOC_ST_IDLE;
                    pready  <= 1'b0;
                    pslverr <= 1'b0;
                end
                default: begin
                    st_reg <= tcoc_pkg::TCOC_ST_IDLE;
                    pready <= 1'b0;
                end
            endcase
        end
    end

    // flags, capture values and accumulator live in the datapath; they read zero here
    always_comb begin
        rd_byte = 8'h00;
        if (mapped) begin
            unique case (idx)
                `TCOC_IDX_CAP_SEL:  rd_byte = cap_sel_reg;
                `TCOC_IDX_OVR_MASK: rd_byte = ovr_mask_reg;
                `TCOC_IDX_OVR_DATA: rd_byte = ovr_data_reg;
                `TCOC_IDX_CNT_HI:   rd_byte = counter_value[15:8];
                `TCOC_IDX_CNT_LO:   rd_byte = counter_value[7:0];
                `TCOC_IDX_SYSCTL1:  rd_byte = sysctl1_reg;
                `TCOC_IDX_TOV:      rd_byte = tov_reg;
                `TCOC_IDX_ACT_HI:   rd_byte = act_hi_reg;
                `TCOC_IDX_ACT_LO:   rd_byte = act_lo_reg;
                `TCOC_IDX_SYSCTL2:  rd_byte = sysctl2_reg;
                `TCOC_IDX_PREC_PSC: rd_byte = prec_psc_reg;
                `TCOC_IDX_PIN_DISC: rd_byte = disc_reg;
                default:            rd_byte = 8'h00;
            endcase
        end
    end

    // ****************************************************************
    // software registers
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_sel_reg  <= `TCOC_RESET_BYTE;
            ovr_mask_reg <= `TCOC_RESET_BYTE;
            ovr_data_reg <= `TCOC_RESET_BYTE;
            tov_reg      <= `TCOC_RESET_BYTE;
            act_hi_reg   <= `TCOC_RESET_BYTE;
            act_lo_reg   <= `TCOC_RESET_BYTE;
            sysctl2_reg  <= `TCOC_RESET_BYTE;
            prec_psc_reg <= `TCOC_RESET_BYTE;
            disc_reg     <= `TCOC_RESET_BYTE;
        end else if (wr_commit) begin
            unique case (idx)
                `TCOC_IDX_CAP_SEL:  cap_sel_reg  <= pwdata[7:0];
                `TCOC_IDX_OVR_MASK: ovr_mask_reg <= pwdata[7:0];
                `TCOC_IDX_OVR_DATA: ovr_data_reg <= pwdata[7:0];
                `TCOC_IDX_TOV:      tov_reg      <= pwdata[7:0];
                `TCOC_IDX_ACT_HI:   act_hi_reg   <= pwdata[7:0];
                `TCOC_IDX_ACT_LO:   act_lo_reg   <= pwdata[7:0];
                `TCOC_IDX_SYSCTL2:  sysctl2_reg  <= pwdata[7:0];
                `TCOC_IDX_PREC_PSC: prec_psc_reg <= pwdata[7:0];
                `TCOC_IDX_PIN_DISC: disc_reg     <= pwdata[7:0];
                default:            ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sysctl1_reg   <= `TCOC_RESET_BYTE;
            precision_prescale_select_lock_reg <= 1'b0;
        end else if (wr_commit && idx == `TCOC_IDX_SYSCTL1) begin
            sysctl1_reg[7:4] <= pwdata[7:4];
            if (!precision_prescale_select_lock_reg) begin
                sysctl1_reg[`TCOC_BIT_PRECISION_PRESCALE_SELECT] <= pwdata[`TCOC_BIT_PRECISION_PRESCALE_SELECT];
            end
            precision_prescale_select_lock_reg <= 1'b1;
        end
    end

    // forced compare is a one cycle strobe, never stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            force_reg <= '0;
        end else begin
            force_reg <= (wr_commit && idx == `TCOC_IDX_FORCE) ? pwdata[7:0] : 8'h00;
        end
    end

    // ****************************************************************
    // prescaler choice
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale_sel   <= 8'h00;
            precision_mode <= 1'b0;
        end else begin
            precision_mode <= precision_prescale_select;
            prescale_sel <= precision_prescale_select ? prec_psc_reg : {5'h00, sysctl2_reg[2:0]};
        end
    end

    // ****************************************************************
    // overflow detection
    // ****************************************************************
    // wrap to zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_prev_reg     <= `TCOC_CNT_ZERO;
            counter_overflow <= 1'b0;
        end else begin
            cnt_prev_reg     <= counter_value;
            counter_overflow <= (cnt_prev_reg == `TCOC_CNT_MAX)
                             && (counter_value == `TCOC_CNT_ZERO);
        end
    end

    // ****************************************************************
    // fast flag clear
    // ****************************************************************
    always_comb begin
        clear_next = '0;
        if (commit && mapped && ffca) begin
            if (tcoc_chan_hit(idx) && (cap_sel_reg[chan] ? pwrite : !pwrite)) begin
                clear_next.chan[chan] = 1'b1;
            end
            clear_next.ovf = tcoc_is_cnt(idx);
            clear_next.acc = tcoc_is_acc(idx);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_clear <= '0;
        end else begin
            flag_clear <= clear_next;
        end
    end

    // ****************************************************************
    // channel pins
    // ****************************************************************
    // channel 7 event
    assign ch7_event = (counter_overflow && tov_reg[7]) || compare_match[7];

    for (genvar k = 0; k < NCH; k++) begin : g_pin
        tcoc_pin_action u_pin (
            .pclk       (pclk),
            .presetn    (presetn),
            .mode_pair  (pairs[2*k +: 2]),
            .cap_sel    (cap_sel_reg[k]),
            .tov_en     (tov_reg[k]),
            .disconnect (disc_reg[k]),
            .ovr_mask   (ovr_mask_reg[k]),
            .ovr_data   (ovr_data_reg[k]),
            .ch7_event  (ch7_event),
            .overflow   (counter_overflow),
            .force_cmp  (force_reg[k]),
            .match      (compare_match[k]),
            .pin_level  (pin_level[k]),
            .pin_oe     (pin_oe[k])
        );
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    apb_one_wait_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("apb answer not after one wait");

    no_fast_clear_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !ffca |=> flag_clear == '0)
        else $error("flag cleared with fast clear off");

    chan_clear_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        commit && ffca && mapped && tcoc_chan_hit(idx) && !pwrite && !cap_sel_reg[chan]
        |=> flag_clear.chan[$past(chan)])
        else $error("capture read did not clear flag");

    cnt_clear_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        commit && ffca && mapped && tcoc_is_cnt(idx) |=> flag_clear.ovf)
        else $error("counter access did not clear overflow");

    acc_clear_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        commit && ffca && mapped && tcoc_is_acc(idx) |=> flag_clear.acc)
        else $error("accumulator access did not clear flags");

    legacy_select_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !precision_prescale_select |=> prescale_sel == {5'h00, $past(sysctl2_reg[2:0])})
        else $error("legacy prescale not selected");

    prec_select_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        precision_prescale_select |=> prescale_sel == $past(prec_psc_reg))
        else $error("precision prescale not selected");

    precision_prescale_select_lock_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        precision_prescale_select_lock_reg |=> precision_prescale_select == $past(precision_prescale_select))
        else $error("precision bit changed after lock");

    wrap_pulse_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        cnt_prev_reg == `TCOC_CNT_MAX && counter_value == `TCOC_CNT_ZERO
        |=> counter_overflow ##1 !counter_overflow)
        else $error("overflow pulse wrong");

endmodule : tcoc_top

// ### include/tcoc_defines.svh
// tcoc_defines.svh: register indices, field positions and reset values of the compare control
`ifndef TCOC_DEFINES_SVH
`define TCOC_DEFINES_SVH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define TCOC_IDX_CAP_SEL    6'h00
`define TCOC_IDX_FORCE      6'h01
`define TCOC_IDX_OVR_MASK   6'h02
`define TCOC_IDX_OVR_DATA   6'h03
`define TCOC_IDX_CNT_HI     6'h04
`define TCOC_IDX_CNT_LO     6'h05
`define TCOC_IDX_SYSCTL1    6'h06
`define TCOC_IDX_TOV        6'h07
`define TCOC_IDX_ACT_HI     6'h08
`define TCOC_IDX_ACT_LO     6'h09
`define TCOC_IDX_SYSCTL2    6'h0D
`define TCOC_IDX_CHFLAG     6'h0E
`define TCOC_IDX_FLAG2      6'h0F
`define TCOC_IDX_CHAN_FIRST 6'h10
`define TCOC_IDX_CHAN_LAST  6'h1F
`define TCOC_IDX_ACC_FLAG   6'h21
`define TCOC_IDX_ACC_HI     6'h22
`define TCOC_IDX_ACC_LO     6'h23
`define TCOC_IDX_PREC_PSC   6'h2B
`define TCOC_IDX_PIN_DISC   6'h2C

// ****************************************************************
// fields and reset values
// ****************************************************************
`define TCOC_CHANNELS       8
`define TCOC_BIT_FFCA       4
`define TCOC_BIT_PRECISION_PRESCALE_SELECT       3
`define TCOC_SYSCTL1_WMASK  8'hF8
`define TCOC_RESET_BYTE     8'h00
`define TCOC_CNT_MAX        16'hFFFF
`define TCOC_CNT_ZERO       16'h0000

`endif

// ### include/tcoc_pkg.sv
// tcoc_pkg.sv: types shared by the compare control modules
package tcoc_pkg;

    typedef enum logic [1:0] {
        TCOC_ACT_KEEP   = 2'h0,
        TCOC_ACT_TOGGLE = 2'h1,
        TCOC_ACT_LOW    = 2'h2,
        TCOC_ACT_HIGH   = 2'h3
    } tcoc_action_t;

    typedef enum logic [1:0] {
        TCOC_ST_IDLE = 2'h1,
        TCOC_ST_DONE = 2'h2
    } tcoc_apb_state_t;

    typedef struct packed {
        logic [7:0] chan;
        logic       ovf;
        logic       acc;
    } tcoc_clear_t;

endpackage : tcoc_pkg

// ### hw/tcoc_pin_action.sv
// tcoc_pin_action.sv: one channel's compare pin level and drive enable
`timescale 1ns/1ps
module tcoc_pin_action (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [1:0] mode_pair,
    input  wire logic       cap_sel,
    input  wire logic       tov_en,
    input  wire logic       disconnect,
    input  wire logic       ovr_mask,
    input  wire logic       ovr_data,
    input  wire logic       ch7_event,
    input  wire logic       overflow,
    input  wire logic       force_cmp,
    input  wire logic       match,
    output logic            pin_level,
    output logic            pin_oe
);

    function automatic logic tcoc_apply(input logic [1:0] m, input logic cur);
        unique case (tcoc_pkg::tcoc_action_t'(m))
            tcoc_pkg::TCOC_ACT_KEEP:   return cur;
            tcoc_pkg::TCOC_ACT_TOGGLE: return ~cur;
            tcoc_pkg::TCOC_ACT_LOW:    return 1'b0;
            tcoc_pkg::TCOC_ACT_HIGH:   return 1'b1;
        endcase
    endfunction : tcoc_apply

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_level <= 1'b0;
        end else if (cap_sel) begin
            if (ch7_event && ovr_mask) begin
                pin_level <= ovr_data;
            end else if (overflow && tov_en) begin
                pin_level <= ~pin_level;
            end else if (force_cmp || match) begin
                pin_level <= tcoc_apply(mode_pair, pin_level);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_oe <= 1'b0;
        end else begin
            pin_oe <= ~disconnect & ((|mode_pair) | (cap_sel & (ovr_mask | tov_en)));
        end
    end

    override_wins_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        cap_sel && ch7_event && ovr_mask |=> pin_level == $past(ovr_data))
        else $error("override data not on pin");

    tov_toggle_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        cap_sel && overflow && tov_en && !(ch7_event && ovr_mask)
        |=> pin_level != $past(pin_level))
        else $error("overflow toggle missed");

    capture_ignored_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !cap_sel |=> $stable(pin_level))
        else $error("pin moved in capture mode");

    drive_high_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        cap_sel && match && mode_pair == 2'h3 && !(ch7_event && ovr_mask)
        && !(overflow && tov_en) |=> pin_level)
        else $error("set action failed");

    disconnect_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        disconnect |=> !pin_oe)
        else $error("disconnected pin driven");

endmodule : tcoc_pin_action

// ### verif/tb_top.sv
// tb_top.sv: self-checking bench for the timer compare output control
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {
        logic [5:0] idx;
        logic       wr;
        logic       ffca;
        logic [9:0] exp;
    } tcoc_frow_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, counter_overflow, precision_mode;
    logic [7:0]  paddr, compare_match, prescale_sel, pin_level, pin_oe;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] counter_value;
    logic        err;
    logic [9:0]  seen;
    tcoc_pkg::tcoc_clear_t flag_clear;
    int mismatches, comparisons;
    tcoc_frow_t frows [9];
    tcoc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .counter_value(counter_value), .compare_match(compare_match),
        .counter_overflow(counter_overflow), .flag_clear(flag_clear),
        .prescale_sel(prescale_sel), .precision_mode(precision_mode),
        .pin_level(pin_level), .pin_oe(pin_oe));
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic tally_and_finish;
        if (mismatches == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // one apb transfer; waits for pready under a bound
    task automatic apb(input logic [5:0] idx, input logic w, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w;
        paddr <= {idx, 2'h0}; pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            mismatches++;
            tally_and_finish;
        end
        rd = prdata; err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : settle
    task automatic pulse_match(input logic [7:0] m);
        @(posedge pclk);
        compare_match <= m;
        @(posedge pclk);
        compare_match <= 8'h00;
        settle(2);
    endtask : pulse_match
    // counter wraps, overflow pulse follows one edge later and lasts one cycle
    task automatic wrap;
        @(posedge pclk);
        counter_value <= 16'hFFFF;
        @(posedge pclk);
        counter_value <= 16'h0000;
        settle(1);
        chk("counter_overflow", 32'h1, counter_overflow);
        settle(1);
        chk("counter_overflow", 32'h0, counter_overflow);
        settle(1);
    endtask : wrap
    initial begin
        logic [1:0] pairs [5];
        logic [7:0] lvls;
        mismatches = 0; comparisons = 0;
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h00000000; counter_value = 16'h1234; compare_match = 8'h00;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(6'h07, 1'b0, 8'h00);
        chk("tov reset", 32'h0, rd);
        apb(6'h3F, 1'b0, 8'h00);
        chk("unmapped err", 32'h1, err);
        // ****************************************************************
        // prescaler choice and its one-time lock
        // ****************************************************************
        apb(6'h0D, 1'b1, 8'h05);
        apb(6'h2B, 1'b1, 8'hA5);
        settle(2);
        chk("prescale legacy", 32'h05, prescale_sel);
        apb(6'h06, 1'b1, 8'h08);
        settle(2);
        chk("prescale precise", 32'hA5, prescale_sel);
        apb(6'h06, 1'b1, 8'h00);
        settle(2);
        chk("precision locked", 32'h1, precision_mode);
        // ****************************************************************
        // fast flag clear rows; capture mode on all channels
        // ****************************************************************
        frows = '{'{6'h04, 1'b0, 1'b0, 10'h000}, '{6'h04, 1'b0, 1'b1, 10'h002},
                  '{6'h05, 1'b1, 1'b1, 10'h002}, '{6'h22, 1'b0, 1'b1, 10'h001},
                  '{6'h23, 1'b1, 1'b1, 10'h001}, '{6'h10, 1'b0, 1'b1, 10'h004},
                  '{6'h1F, 1'b0, 1'b1, 10'h200}, '{6'h12, 1'b1, 1'b1, 10'h000},
                  '{6'h22, 1'b1, 1'b0, 10'h000}};
        foreach (frows[i]) begin
            apb(6'h06, 1'b1, {3'h0, frows[i].ffca, 4'h8});
            apb(frows[i].idx, frows[i].wr, 8'h3C);
            seen = '0;
            repeat (4) begin
                @(posedge pclk);
                seen |= flag_clear;
            end
            chk("flag_clear", {22'h0, frows[i].exp}, {22'h0, seen});
        end
        apb(6'h00, 1'b1, 8'h04);
        apb(6'h06, 1'b1, 8'h18);
        apb(6'h14, 1'b1, 8'h11);
        seen = '0;
        repeat (4) begin
            @(posedge pclk);
            seen |= flag_clear;
        end
        chk("compare write clear", 32'h010, {22'h0, seen});
        // ****************************************************************
        // compare actions on channel 0
        // ****************************************************************
        apb(6'h00, 1'b1, 8'h81);
        pairs = '{2'h3, 2'h0, 2'h1, 2'h2, 2'h1};
        lvls = 8'h13;
        foreach (pairs[i]) begin
            apb(6'h09, 1'b1, {6'h00, pairs[i]});
            pulse_match(8'h01);
            chk("pin_level0", {31'h0, lvls[i]}, {31'h0, pin_level[0]});
            chk("pin_oe0", {31'h0, pairs[i] != 2'h0}, {31'h0, pin_oe[0]});
        end
        apb(6'h2C, 1'b1, 8'h01);
        settle(2);
        chk("pin_oe0 disc", 32'h0, {31'h0, pin_oe[0]});
        apb(6'h2C, 1'b1, 8'h00);
        apb(6'h07, 1'b1, 8'h03);
        apb(6'h07, 1'b0, 8'h00);
        chk("tov readback", 32'h03, rd);
        wrap;
        chk("pins after wrap", 32'h0, {30'h0, pin_level[1:0]});
        chk("pin_oe1 capture", 32'h0, {31'h0, pin_oe[1]});
        apb(6'h07, 1'b1, 8'h00);
        apb(6'h02, 1'b1, 8'h01);
        apb(6'h03, 1'b1, 8'h00);
        pulse_match(8'h81);
        chk("ch7 override 0", 32'h0, {31'h0, pin_level[0]});
        apb(6'h03, 1'b1, 8'h01);
        pulse_match(8'h80);
        chk("ch7 override 1", 32'h1, {31'h0, pin_level[0]});
        apb(6'h02, 1'b1, 8'h00);
        apb(6'h01, 1'b1, 8'h01);
        settle(2);
        chk("force toggle", 32'h0, {31'h0, pin_level[0]});
        // ****************************************************************
        // second reset: lock released, then taken at zero
        // ****************************************************************
        @(posedge pclk);
        presetn <= 1'b0;
        settle(2);
        chk("pins in reset", 32'h0, {24'h0, pin_level});
        chk("precision in reset", 32'h0, {31'h0, precision_mode});
        @(posedge pclk);
        presetn <= 1'b1;
        apb(6'h06, 1'b1, 8'h00);
        apb(6'h06, 1'b1, 8'h08);
        settle(2);
        chk("precision relocked", 32'h0, {31'h0, precision_mode});
        tally_and_finish;
    end
endmodule : tb_top
